//--- slcr_pkg.sv
// package for the serial lane control register bank
// assumes a plain register port with word addressing by byte offset
package slcr_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] LANE_ONE_CTRL_ADDR = 8'h08;
    localparam logic [7:0] LANE_TWO_CTRL_ADDR = 8'h0C;
    localparam logic [7:0] LANE_THREE_CTRL_ADDR = 8'h10;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int LANE_DATA_W = 32;
    localparam int NUM_LANES = 4;
    localparam int FIRST_LANE = 1;
    // ****************************************
    // field layout
    // ****************************************
    localparam int INVERT_BIT = 0;
    localparam int SLEEP_BIT = 1;
    localparam int SPARE_LSB = 2;
    localparam int SPARE_W = 8;
    localparam int FIELD_W = 10;
    localparam logic [FIELD_W-1:0] CTRL_RESET = 10'h000;
endpackage

//--- slcr_regs.sv
// lane control registers for lanes one to three with tx polarity inversion
// assumes one clock, a synchronous reset and a one-cycle-latency register port
// ****************************************
// Notes on behaviour
// ****************************************
// Notes on behaviour
// - a lane's bit 0 set to 1 inverts every bit of its transmit data, at 0 data passes unchanged.
// - a lane's bit 1 drives the power-down vector bit whose index is the lane number.
// - the transport stage reads the power-down vector to see which lanes were dropped.
// - bits 9:2 are a spare read-write field resetting to zero.
// - the lane two register sits at offset 0xC and resets to zero.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ns
module slcr_regs (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    // register port
    input wire logic [slcr_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic [slcr_pkg::DATA_W-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [slcr_pkg::DATA_W-1:0] RDATA_O,
    // transmit data, lanes one to three (index 0 unused)
    input wire logic [slcr_pkg::LANE_DATA_W-1:0] TX_DATA_I [slcr_pkg::NUM_LANES],
    output logic [slcr_pkg::LANE_DATA_W-1:0] TX_DATA_O [slcr_pkg::NUM_LANES],
    // lane power-down vector
    output logic [slcr_pkg::NUM_LANES-1:0] LANE_SLEEP_O
);
    // ****************************************
    // decode
    // ****************************************
    // lane index from address, 0 when unmapped
    function automatic int unsigned lane_of(input logic [slcr_pkg::ADDR_W-1:0] a);
        int unsigned n;
        n = 0;
        if (a == slcr_pkg::LANE_ONE_CTRL_ADDR) begin
            n = 1;
        end else if (a == slcr_pkg::LANE_TWO_CTRL_ADDR) begin
            n = 2;
        end else if (a == slcr_pkg::LANE_THREE_CTRL_ADDR) begin
            n = 3;
        end
        return n;
    endfunction

    logic [slcr_pkg::FIELD_W-1:0] lane_ctrl [slcr_pkg::NUM_LANES];

    // ****************************************
    // per-lane registers and datapath
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < slcr_pkg::NUM_LANES; g++) begin : g_lane
            // only the low ten bits are stored, upper write bits dropped
            // lane zero is outside this bank: it never takes a write, and since
            // unmapped addresses decode to zero they must not land there either
            always_ff @(posedge CORE_CLK_I) begin
                if (RST_I) begin
                    lane_ctrl[g] <= slcr_pkg::CTRL_RESET;
                end else if (WR_I && g >= slcr_pkg::FIRST_LANE && lane_of(ADDR_I) == g) begin
                    lane_ctrl[g] <= WDATA_I[slcr_pkg::FIELD_W-1:0];
                end
            end
            // registered inversion keeps outputs straight from flops
            // lane zero output held idle so nothing leaks through an unused lane
            always_ff @(posedge CORE_CLK_I) begin
                if (RST_I || g < slcr_pkg::FIRST_LANE) begin
                    TX_DATA_O[g] <= '0;
                end else begin
                    TX_DATA_O[g] <= TX_DATA_I[g]
                        ^ {slcr_pkg::LANE_DATA_W{lane_ctrl[g][slcr_pkg::INVERT_BIT]}};
                end
            end
        end
    endgenerate

    // power-down vector, also read by the transport stage and reset controller
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            LANE_SLEEP_O <= '0;
        end else begin
            for (int i = 0; i < slcr_pkg::NUM_LANES; i++) begin
                LANE_SLEEP_O[i] <= lane_ctrl[i][slcr_pkg::SLEEP_BIT];
            end
        end
    end

    // ****************************************
    // read path
    // ****************************************
    // unmapped addresses read zero; upper bits always zero
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            RDATA_O <= '0;
        end else if (RD_I) begin
            RDATA_O <= {{(slcr_pkg::DATA_W-slcr_pkg::FIELD_W){1'b0}},
                lane_ctrl[lane_of(ADDR_I)]};
        end else begin
            RDATA_O <= '0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_invert_lane_two: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        lane_ctrl[2][0] && !$past(RST_I) |=> TX_DATA_O[2] == ~$past(TX_DATA_I[2]))
        else $error("lane two data not inverted");
    a_pass_lane_three: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        !lane_ctrl[3][0] |=> TX_DATA_O[3] == $past(TX_DATA_I[3]))
        else $error("lane three data altered");
    a_sleep_follows_write: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        WR_I && ADDR_I == 8'h0C ##1 !(WR_I && ADDR_I == 8'h0C)
        |=> LANE_SLEEP_O[2] == $past(WDATA_I[1], 2))
        else $error("lane two sleep bit wrong");
    a_sleep_lane_one: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        ##1 LANE_SLEEP_O[1] == $past(lane_ctrl[1][1]))
        else $error("lane one sleep bit wrong");
    a_spare_readback: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        WR_I && ADDR_I == 8'h10 ##1 RD_I && ADDR_I == 8'h10
        |=> RDATA_O[9:2] == $past(WDATA_I[9:2], 2))
        else $error("spare field readback wrong");
    a_reset_lane_two: assert property (@(posedge CORE_CLK_I)
        $past(RST_I) |-> lane_ctrl[2] == 10'h000)
        else $error("lane two not reset to zero");
    a_upper_bits_zero: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        RDATA_O[31:10] == 22'h000000)
        else $error("reserved bits not zero");
    a_idle_read_zero: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        !RD_I |=> RDATA_O == 32'h00000000)
        else $error("read data outside read cycle");

    // ****************************************
    // checks: polarity inversion per lane
    // ****************************************
    // each lane is checked both ways, so a swapped lane index shows up
    a_invert_lane_one: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        lane_ctrl[1][0] |=> TX_DATA_O[1] == ~$past(TX_DATA_I[1]))
        else $error("lane one data not inverted");
    a_pass_lane_one: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        !lane_ctrl[1][0] |=> TX_DATA_O[1] == $past(TX_DATA_I[1]))
        else $error("lane one data altered");
    a_pass_lane_two: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        !lane_ctrl[2][0] |=> TX_DATA_O[2] == $past(TX_DATA_I[2]))
        else $error("lane two data altered");
    a_invert_lane_three: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        lane_ctrl[3][0] |=> TX_DATA_O[3] == ~$past(TX_DATA_I[3]))
        else $error("lane three data not inverted");
    // unused lane must stay quiet whatever comes in
    a_lane_zero_quiet: assert property (@(posedge CORE_CLK_I)
        TX_DATA_O[0] == 32'h00000000)
        else $error("lane zero data not idle");

    // ****************************************
    // checks: power-down vector
    // ****************************************
    // one cycle behind the register, as the flop stage adds a cycle
    a_sleep_lane_two: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        ##1 LANE_SLEEP_O[2] == $past(lane_ctrl[2][1]))
        else $error("lane two sleep bit does not follow register");
    a_sleep_lane_three: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        ##1 LANE_SLEEP_O[3] == $past(lane_ctrl[3][1]))
        else $error("lane three sleep bit does not follow register");
    // bit zero belongs to a lane outside this bank
    a_sleep_lane_zero: assert property (@(posedge CORE_CLK_I)
        !LANE_SLEEP_O[0])
        else $error("lane zero sleep bit set");

    // ****************************************
    // checks: field storage
    // ****************************************
    // the whole ten-bit field is taken from the write word
    a_write_lane_one: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        WR_I && ADDR_I == 8'h08 |=> lane_ctrl[1] == $past(WDATA_I[9:0]))
        else $error("lane one write not stored");
    a_write_lane_two: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        WR_I && ADDR_I == 8'h0C |=> lane_ctrl[2] == $past(WDATA_I[9:0]))
        else $error("lane two write not stored");
    a_write_lane_three: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        WR_I && ADDR_I == 8'h10 |=> lane_ctrl[3] == $past(WDATA_I[9:0]))
        else $error("lane three write not stored");
    // a stray address must not disturb any lane
    a_unmapped_write_ignored: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        WR_I && lane_of(ADDR_I) == 0
        |=> $stable(lane_ctrl[1]) && $stable(lane_ctrl[2]) && $stable(lane_ctrl[3]))
        else $error("unmapped write changed a lane");
    a_reset_lane_one: assert property (@(posedge CORE_CLK_I)
        $past(RST_I) |-> lane_ctrl[1] == 10'h000)
        else $error("lane one not reset to zero");
    a_reset_lane_three: assert property (@(posedge CORE_CLK_I)
        $past(RST_I) |-> lane_ctrl[3] == 10'h000)
        else $error("lane three not reset to zero");

    // ****************************************
    // checks: read path and reset outputs
    // ****************************************
    // read data is the stored field, zero-extended
    a_read_lane_two: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        RD_I && ADDR_I == 8'h0C |=> RDATA_O == {22'h000000, $past(lane_ctrl[2])})
        else $error("lane two read data wrong");
    a_unmapped_read_zero: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        RD_I && lane_of(ADDR_I) == 0 |=> RDATA_O == 32'h00000000)
        else $error("unmapped read not zero");
    // outputs are quiet on the edge after a reset edge
    a_reset_outputs: assert property (@(posedge CORE_CLK_I)
        $past(RST_I) |-> LANE_SLEEP_O == 4'h0 && RDATA_O == 32'h00000000)
        else $error("outputs not zero after reset");
endmodule

//--- test_serial_lane_control_regs.sv
// self-checking bench for the lane control register bank
// assumes the package and slcr_regs are compiled before this file
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fails++; \
    $display("[ERR] %s expected %h seen %h", n, e, s); end end
module test_serial_lane_control_regs;
    logic CORE_CLK_I, RST_I, WR_I, RD_I, rd_q;
    logic [7:0] ADDR_I;
    logic [31:0] WDATA_I, RDATA_O, lfsr, w, e;
    logic [31:0] TX_DATA_I [4];
    logic [31:0] TX_DATA_O [4];
    logic [31:0] val [4];
    logic [3:0] LANE_SLEEP_O, sl;
    logic [31:0] expq [$];
    int fails, compares, i, r, n;
    slcr_regs slcr_regs_inst (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
        .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
        .TX_DATA_I(TX_DATA_I), .TX_DATA_O(TX_DATA_O), .LANE_SLEEP_O(LANE_SLEEP_O));
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // one strobe per call; strobes change once per edge, so calls may run back to back
    task automatic op(input logic wr, input logic [7:0] a, input logic [31:0] d);
        WR_I <= wr;
        RD_I <= !wr;
        ADDR_I <= a;
        WDATA_I <= d;
        if (!wr) expq.push_back(d);
        @(posedge CORE_CLK_I);
    endtask
    task automatic stop_test;
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        CORE_CLK_I = 1'b0;
        forever #4 CORE_CLK_I = ~CORE_CLK_I;
    end
    // read data stands only in the cycle after the strobe, so sample exactly there
    always @(posedge CORE_CLK_I) begin
        if (rd_q === 1'b1) begin
            e = expq.pop_front();
            `CHK("rdata", e, RDATA_O)
        end
        rd_q <= RD_I;
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {RST_I, WR_I, RD_I, rd_q, ADDR_I, WDATA_I, lfsr} = {1'b1, 35'h0, 40'h8};
        {fails, compares, sl} = 0;
        for (i = 0; i < 4; i++) {TX_DATA_I[i], val[i]} = 64'h0;
        repeat (6) @(posedge CORE_CLK_I);
        RST_I <= 1'b0;
        // reset values, unmapped words on both sides
        for (i = 1; i < 6; i++) op(1'b0, 8'(4 * i), 32'h0);
        for (r = 0; r < 8; r++) begin
            for (n = 1; n < 4; n++) begin
                w = lfsr;
                lfsr = next_rand(lfsr);
                TX_DATA_I[n] <= lfsr;
                TX_DATA_I[0] <= ~lfsr;
                val[n] = w & 32'h3FF;
                sl[n] = w[1];
                op(1'b1, 8'(4 + 4 * n), w);
                op(1'b0, 8'(4 + 4 * n), val[n]);
                op(1'b1, 8'h14, 32'hFFFFFFFF);
                {WR_I, RD_I} <= 2'b00;
                repeat (2) @(posedge CORE_CLK_I);
                #1;
                `CHK("sleep", sl, LANE_SLEEP_O)
                `CHK("tx0", 32'h0, TX_DATA_O[0])
                `CHK("tx", w[0] ? ~lfsr : lfsr, TX_DATA_O[n])
                @(posedge CORE_CLK_I);
            end
        end
        // unmapped writes left every lane untouched
        for (n = 1; n < 4; n++) op(1'b0, 8'(4 + 4 * n), val[n]);
        {WR_I, RD_I} <= 2'b00;
        for (i = 0; i < 10 && expq.size() != 0; i++) @(posedge CORE_CLK_I);
        if (expq.size() != 0) fails++;
        stop_test();
    end
endmodule
